/* File: verilog/pdo_cfg_pkg.sv */
// Constants and types shared by the bit-rate and process-data mapping block
package pdo_cfg_pkg;
	// Register offsets are word indices; byte address is four times the index
	localparam logic [11:0] idx_fixed_rate = 12'h000;
	localparam logic [11:0] idx_auto_rate = 12'h005;
	localparam logic [11:0] idx_activation = 12'h00A;
	localparam logic [11:0] idx_write_prot = 12'h010;
	localparam logic [11:0] idx_restart = 12'h011;
	localparam logic [11:0] idx_active_rate = 12'h012;
	localparam logic [11:0] idx_id_ext = 12'h013;
	localparam logic [11:0] idx_modules = 12'h014;
	localparam logic [11:0] idx_map_count = 12'h020;
	localparam logic [11:0] idx_pdo_base = 12'h040;
	localparam logic [11:0] idx_map_base = 12'h080;
	localparam logic [11:0] idx_dio_base = 12'h100;
	// Field values
	localparam logic [15:0] activation_key = 16'h8000;
	localparam logic [15:0] rate_code_max = 16'h0009;
	localparam logic [15:0] unlock_key = 16'h0001;
	localparam logic [15:0] restart_key = 16'h0001;
	localparam logic [15:0] reset_zero = 16'h0000;
	localparam logic [3:0] max_pdo_bytes = 4'h8;
	localparam int n_pdo = 16;
	localparam int n_default_id = 4;
	localparam int n_ext_id = 11;
	// Dictionary objects holding process data
	localparam logic [15:0] obj_dig_in = 16'h6000;
	localparam logic [15:0] obj_dig_out = 16'h6200;
	localparam logic [15:0] obj_ana_in = 16'h6401;
	localparam logic [15:0] obj_ana_out = 16'h6411;
	localparam logic [15:0] obj_spc_in = 16'h2800;
	localparam logic [15:0] obj_spc_out = 16'h2900;
	// Transfer modes per object
	typedef enum logic [1:0] {mode_event, mode_polled, mode_sync} xfer_mode_e;
	// Data type assigned to a process data object
	typedef enum logic [1:0] {kind_none, kind_digital, kind_analog, kind_special} data_kind_e;
	typedef struct packed {
		logic [7:0] n_dig_in;
		logic [7:0] n_dig_out;
		logic [3:0] n_ana_in;
		logic [3:0] n_ana_out;
		logic [3:0] n_spc_in_bytes;
		logic [3:0] n_spc_out_bytes;
	} module_set_s;
endpackage : pdo_cfg_pkg

/* File: verilog/canopen_baud_and_pdo_mapping.sv */
// Bit-rate selection, start-up process-data mapping and identifier setup
// What this block does
// - Parameter word 0 holds a rate code; 0 is 1 Mbit/auto, 1..9 fixed rates.
// - The stored code takes effect only when activation word 10 enables it.
// - Objects 1 to 3 carry at most eight data bytes; object 4 takes up to eleven.
// - Digital bits go into objects in physical channel order.
// - The first four analog channels sit in the second object.
// - An object reserved for an absent data type stays empty.
// - Digital data in object 1, analog in object 2, special in object 3.
// - At start-up modules are discovered; types are never mixed in one object.
// - A separate count table at word 0x20 returns the count of mapped entries.
// - Receive and transmit mapping tables are readable by the master.
// - Default identifiers exist for four receive and four transmit objects.
// - Only analog channels beyond four spill into object 4; objects 5 to 16 stay empty.
// - Writing the extension control enables identifiers for objects 5 to 11.
// - Each object identifier can be set individually.
// - Per object, event-driven by default, polled and synchronised selectable.
// - Process data of objects 1 to 3 lives in the default dictionary objects per type; object 4 entries name object 0x0000.
// - Digital channels beyond 64 are not mapped; object 1 stops at eight digital entries.
// - A software restart skips detection; it keeps the active bit rate unless an activated fixed rate replaces it.
`timescale 1ns/1ps
module canopen_baud_and_pdo_mapping #(
	parameter int node_id = 11, // Node address used for default identifiers
	parameter int dig_bits = 64 // Digital channels carried in the image
) (
	input wire logic pclk, // APB clock, 10 MHz
	input wire logic presetn, // Asynchronous reset, active low
	input wire logic psel, // APB select
	input wire logic penable, // APB enable
	input wire logic pwrite, // APB direction
	input wire logic [13:0] paddr, // APB byte address
	input wire logic [31:0] pwdata, // APB write data
	output logic [31:0] prdata, // APB read data
	output logic pready, // APB ready
	output logic pslverr, // APB error on unmapped address
	input wire logic [31:0] module_set_pin, // Attached module inventory, asynchronous
	input wire logic auto_rate_found, // Detector found a rate, asynchronous
	input wire logic [3:0] auto_rate_code, // Rate the detector found
	input wire logic [63:0] dig_in_pin, // Digital inputs, asynchronous
	output logic [3:0] rate_code, // Rate code in use
	output logic rate_valid, // Rate code is settled
	output logic [63:0] dig_out_q, // Digital outputs
	output logic startup_busy // Start-up mapping in progress
);
	// The image and the 11-bit identifier formula serve only these values
	if (dig_bits != 64 || node_id < 1 || node_id > 127)
	begin : g_bad_param
		$error("dig_bits must be 64 and node_id 1 to 127");
	end

	// ---------------------------------------------------------------
	// Synchronisers
	// ---------------------------------------------------------------
	logic [31:0] mod_s1_q, mod_s2_q;
	logic [63:0] din_s1_q, din_s2_q;
	logic [1:0] found_s_q;
	logic [3:0] code_s1_q, code_s2_q;
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			mod_s1_q <= '0;
			mod_s2_q <= '0;
			din_s1_q <= '0;
			din_s2_q <= '0;
			found_s_q <= '0;
			code_s1_q <= '0;
			code_s2_q <= '0;
		end
		else
		begin
			mod_s1_q <= module_set_pin;
			mod_s2_q <= mod_s1_q;
			din_s1_q <= dig_in_pin;
			din_s2_q <= din_s1_q;
			found_s_q <= {found_s_q[0], auto_rate_found};
			code_s1_q <= auto_rate_code;
			code_s2_q <= code_s1_q;
		end

	// ---------------------------------------------------------------
	// APB decode
	// ---------------------------------------------------------------
	wire [11:0] idx = paddr[13:2];
	wire wr_en = psel && penable && pwrite && pready;
	wire rd_en = psel && penable && !pwrite;
	wire hit_rate = idx == pdo_cfg_pkg::idx_fixed_rate;
	wire hit_auto = idx == pdo_cfg_pkg::idx_auto_rate;
	wire hit_act = idx == pdo_cfg_pkg::idx_activation;
	wire hit_prot = idx == pdo_cfg_pkg::idx_write_prot;
	wire hit_rst = idx == pdo_cfg_pkg::idx_restart;
	wire hit_arate = idx == pdo_cfg_pkg::idx_active_rate;
	wire hit_ext = idx == pdo_cfg_pkg::idx_id_ext;
	wire hit_mods = idx == pdo_cfg_pkg::idx_modules;
	wire hit_cnt = idx[11:5] == pdo_cfg_pkg::idx_map_count[11:5];
	wire hit_pdo = idx[11:6] == pdo_cfg_pkg::idx_pdo_base[11:6];
	wire hit_map = idx[11:6] == pdo_cfg_pkg::idx_map_base[11:6];
	wire hit_dio = idx[11:2] == pdo_cfg_pkg::idx_dio_base[11:2];
	wire hit_any = hit_rate || hit_auto || hit_act || hit_prot || hit_rst || hit_arate || hit_ext
		|| hit_mods || hit_cnt || hit_pdo || hit_map || hit_dio;

	// ---------------------------------------------------------------
	// Parameter table and start-up control
	// ---------------------------------------------------------------
	logic [15:0] fixed_rate_code_q, auto_rate_control_q, fixed_rate_activation_q;
	logic unlocked_q, id_ext_q, cold_q;
	typedef enum {st_detect, st_scan, st_run} boot_e;
	boot_e boot_q;
	logic [3:0] rate_q;
	logic rate_ok_q;
	logic [4:0] scan_q;
	pdo_cfg_pkg::module_set_s mods_q;
	wire pdo_cfg_pkg::module_set_s mods_in = mod_s2_q;
	// Writes to the rate table are ignored while write protection is on
	wire tbl_wr = wr_en && unlocked_q;
	wire restart_wr = wr_en && hit_rst && pwdata[15:0] == pdo_cfg_pkg::restart_key;
	// Fixed rate only counts when activated and within the table
	wire fixed_on = fixed_rate_activation_q == pdo_cfg_pkg::activation_key
		&& fixed_rate_code_q <= pdo_cfg_pkg::rate_code_max;

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			fixed_rate_code_q <= pdo_cfg_pkg::reset_zero;
			auto_rate_control_q <= pdo_cfg_pkg::reset_zero;
			fixed_rate_activation_q <= pdo_cfg_pkg::reset_zero;
			unlocked_q <= 1'b0;
			id_ext_q <= 1'b0;
		end
		else
		begin
			if (tbl_wr && hit_rate)
				fixed_rate_code_q <= pwdata[15:0];
			if (tbl_wr && hit_auto)
				auto_rate_control_q <= pwdata[15:0];
			if (tbl_wr && hit_act)
				fixed_rate_activation_q <= pwdata[15:0];
			if (wr_en && hit_prot)
				unlocked_q <= pwdata[15:0] == pdo_cfg_pkg::unlock_key;
			if (wr_en && hit_ext)
				id_ext_q <= pwdata[0];
		end

	// Start-up sequencer: rate is chosen first, then modules are scanned
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			boot_q <= st_detect;
			rate_q <= '0;
			rate_ok_q <= 1'b0;
			cold_q <= 1'b1;
			scan_q <= '0;
			mods_q <= '0;
		end
		else
		begin
			case (boot_q)
				st_detect:
				begin
					// Rate is held from before a software restart
					if (!cold_q)
						boot_q <= st_scan;
					else if (fixed_on)
					begin
						rate_q <= fixed_rate_code_q[3:0];
						rate_ok_q <= 1'b1;
						boot_q <= st_scan;
					end
					else if (found_s_q[1])
					begin
						rate_q <= code_s2_q;
						rate_ok_q <= 1'b1;
						boot_q <= st_scan;
					end
					scan_q <= '0;
				end
				st_scan:
				begin
					// Let the inventory settle through the synchroniser
					scan_q <= scan_q + 5'h01;
					if (scan_q == 5'h03)
					begin
						mods_q <= mods_in;
						boot_q <= st_run;
					end
				end
				st_run:
					if (restart_wr)
					begin
						cold_q <= 1'b0;
						boot_q <= st_detect;
						// An activated fixed rate replaces the old one on restart
						if (fixed_on)
							rate_q <= fixed_rate_code_q[3:0];
					end
				default:
					boot_q <= st_detect;
			endcase
		end

	// ---------------------------------------------------------------
	// Default mapping
	// ---------------------------------------------------------------
	// Object 1 digital, 2 analog, 3 special; types never shared
	function automatic logic [7:0] entries(input logic [7:0] bits, input logic [3:0] ana,
		input logic [3:0] spc, input logic [3:0] obj);
		logic [7:0] n;
		n = 8'h00;
		case (obj)
			4'h1: n = (bits > 8'h40) ? 8'h08 : {3'b000, bits[7:3]} + {7'b0, |bits[2:0]};
			4'h2: n = {4'h0, (ana > 4'h4) ? 4'h4 : ana};
			4'h3: n = {4'h0, (spc > pdo_cfg_pkg::max_pdo_bytes) ? pdo_cfg_pkg::max_pdo_bytes : spc};
			4'h4: n = (ana > 4'h4) ? {4'h0, ana - 4'h4} : 8'h00;
			default: n = 8'h00;
		endcase
		return n;
	endfunction : entries

	// Entry counts per object; index bit 4 selects transmit
	logic [7:0] cnt_rx [0:15];
	logic [7:0] cnt_tx [0:15];
	logic [15:0] pdo_id [0:31];
	logic [1:0] pdo_mode [0:31];
	genvar g;
	generate
		for (g = 0; g < pdo_cfg_pkg::n_pdo; g++)
		begin : g_cnt
			assign cnt_rx[g] = entries(mods_q.n_dig_out, mods_q.n_ana_out, mods_q.n_spc_out_bytes,
				4'(g + 1));
			assign cnt_tx[g] = entries(mods_q.n_dig_in, mods_q.n_ana_in, mods_q.n_spc_in_bytes,
				4'(g + 1));
		end
	endgenerate

	// Object index named by a mapping entry: type object and sub-index
	wire [5:0] msel = idx[5:0];
	wire [3:0] mobj = {1'b0, msel[5:3]};
	wire [7:0] msub = {5'h00, msel[2:0]} + 8'h01;
	wire mtx = paddr[13:2] >= pdo_cfg_pkg::idx_map_base && msel[5];
	logic [15:0] map_obj;
	always_comb
	begin
		map_obj = 16'h0000;
		case (mobj[1:0])
			2'h0: map_obj = mtx ? pdo_cfg_pkg::obj_dig_in : pdo_cfg_pkg::obj_dig_out;
			2'h1: map_obj = mtx ? pdo_cfg_pkg::obj_ana_in : pdo_cfg_pkg::obj_ana_out;
			2'h2: map_obj = mtx ? pdo_cfg_pkg::obj_spc_in : pdo_cfg_pkg::obj_spc_out;
			default: map_obj = 16'h0000;
		endcase
	end
	wire [7:0] mcount = mtx ? cnt_tx[{2'b00, mobj[1:0]}] : cnt_rx[{2'b00, mobj[1:0]}];
	// Digital sub-indices are the object 1 sub-indices unchanged; digital never reaches a later object
	wire [7:0] mdig_sub = msub;
	wire [31:0] map_word = (msub <= mcount) ? {map_obj, mobj[1:0] == 2'h0 ? mdig_sub : msub, 8'h08}
		: 32'h0;

	// ---------------------------------------------------------------
	// Identifiers and transfer modes
	// ---------------------------------------------------------------
	logic [15:0] id_q [0:31];
	logic [1:0] mode_q [0:31];
	logic [31:0] id_set_q;
	wire [4:0] psel_i = idx[4:0];
	function automatic logic [15:0] default_id(input logic [4:0] i, input logic ext);
		logic [3:0] n;
		n = i[3:0];
		// Four per direction by default, seven more when extended
		if (n < 4'(pdo_cfg_pkg::n_default_id))
			return 16'(11'h180 + {n, 7'h00} + (i[4] ? 11'h000 : 11'h080) + 11'(node_id));
		else if (ext && n < 4'(pdo_cfg_pkg::n_ext_id))
			return 16'(11'h1C0 + {n, 6'h00} + (i[4] ? 11'h000 : 11'h020) + 11'(node_id));
		return 16'h8000;
	endfunction : default_id
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			for (int i = 0; i < 32; i++)
			begin
				id_q[i] <= 16'h0000;
				mode_q[i] <= 2'(pdo_cfg_pkg::mode_event);
			end
			id_set_q <= '0;
		end
		else if (wr_en && hit_pdo && !idx[5])
		begin
			id_q[psel_i] <= pwdata[15:0];
			id_set_q[psel_i] <= 1'b1;
		end
		else if (wr_en && hit_pdo && idx[5] && pwdata[1:0] != 2'b11)
			mode_q[psel_i] <= pwdata[1:0];
	generate
		for (g = 0; g < 32; g++)
		begin : g_id
			assign pdo_id[g] = id_set_q[g] ? id_q[g] : default_id(5'(g), id_ext_q);
			assign pdo_mode[g] = mode_q[g];
		end
	endgenerate

	// ---------------------------------------------------------------
	// Digital image in physical order
	// ---------------------------------------------------------------
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			dig_out_q <= '0;
		else if (wr_en && hit_dio && idx[1:0] == 2'h0)
			dig_out_q[31:0] <= pwdata;
		else if (wr_en && hit_dio && idx[1:0] == 2'h1)
			dig_out_q[63:32] <= pwdata;

	// ---------------------------------------------------------------
	// Read mux and outputs
	// ---------------------------------------------------------------
	logic [31:0] rd_d;
	always_comb
	begin
		rd_d = 32'h0;
		if (hit_rate)
			rd_d = {16'h0, fixed_rate_code_q};
		else if (hit_auto)
			rd_d = {16'h0, auto_rate_control_q};
		else if (hit_act)
			rd_d = {16'h0, fixed_rate_activation_q};
		else if (hit_prot)
			rd_d = {31'h0, unlocked_q};
		else if (hit_rst)
			rd_d = {30'h0, boot_q == st_run, !cold_q};
		else if (hit_arate)
			rd_d = {27'h0, rate_ok_q, rate_q};
		else if (hit_ext)
			rd_d = {31'h0, id_ext_q};
		else if (hit_mods)
			rd_d = mods_q;
		else if (hit_cnt)
			rd_d = {24'h0, idx[4] ? cnt_tx[idx[3:0]] : cnt_rx[idx[3:0]]};
		else if (hit_pdo)
			rd_d = idx[5] ? {30'h0, pdo_mode[psel_i]} : {16'h0, pdo_id[psel_i]};
		else if (hit_map)
			rd_d = map_word;
		else if (hit_dio)
			rd_d = idx[1] ? (idx[0] ? din_s2_q[63:32] : din_s2_q[31:0])
				: (idx[0] ? dig_out_q[63:32] : dig_out_q[31:0]);
	end

	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
		begin
			prdata <= '0;
			pready <= 1'b0;
			pslverr <= 1'b0;
			rate_code <= '0;
			rate_valid <= 1'b0;
			startup_busy <= 1'b1;
		end
		else
		begin
			// One wait state: answer registered in the first access cycle
			pready <= psel && penable && !pready;
			pslverr <= psel && penable && !pready && !hit_any;
			if (rd_en && !pready)
				prdata <= hit_any ? rd_d : 32'h0;
			rate_code <= rate_q;
			rate_valid <= rate_ok_q;
			startup_busy <= boot_q != st_run;
		end
endmodule : canopen_baud_and_pdo_mapping

/* File: sim/pdo_cfg_sva.sv */
// Port checker for the bit-rate and process-data mapping block
`timescale 1ns/1ps
module pdo_cfg_sva (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire logic psel, // Select
	input wire logic penable, // Enable
	input wire logic pwrite, // Direction
	input wire logic [31:0] prdata, // Read data
	input wire logic pready, // Ready
	input wire logic pslverr, // Error
	input wire logic [3:0] rate_code, // Rate in use
	input wire logic rate_valid, // Rate settled
	input wire logic [63:0] dig_out_q, // Digital outputs
	input wire logic startup_busy // Mapping scan running
);
	default clocking cb @(posedge pclk);
	endclocking
	default disable iff (!presetn);
	// ----------------------------------------
	// Bus handshake
	// ----------------------------------------
	a_ready_pulse: assert property (pready |=> !pready) else $error("ready held past one cycle");
	a_ready_timing: assert property ($rose(psel && penable) |=> pready) else $error("ready not one cycle after access");
	a_err_ready: assert property (pslverr |-> pready) else $error("error without ready");
	a_read_hold: assert property ($changed(prdata) |-> $past(psel && penable && !pwrite)) else $error("read data moved");
	// ----------------------------------------
	// Rate, start-up and digital outputs
	// ----------------------------------------
	a_code_range: assert property (rate_valid |-> rate_code <= 4'h9) else $error("rate code out of range");
	a_rate_hold: assert property (rate_valid && !startup_busy ##1 !startup_busy |-> $stable(rate_code))
		else $error("rate changed outside start-up");
	a_rate_keep: assert property (rate_valid |=> rate_valid) else $error("rate lost after settling");
	a_busy_rate: assert property (!rate_valid |-> startup_busy) else $error("mapping done before rate");
	a_dout_write: assert property ($changed(dig_out_q) |-> $past(psel && penable && pwrite))
		else $error("outputs moved without a write");
endmodule : pdo_cfg_sva

bind canopen_baud_and_pdo_mapping pdo_cfg_sva u_pdo_cfg_sva (.pclk(pclk), .presetn(presetn), .psel(psel),
	.penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
	.rate_code(rate_code), .rate_valid(rate_valid), .dig_out_q(dig_out_q), .startup_busy(startup_busy));

/* File: sim/io_side_model.sv */
// Model of the attached modules and the bit-rate detector
`timescale 1ns/1ps
module io_side_model (
	input wire logic pclk, // Clock
	input wire logic presetn, // Reset, active low
	input wire pdo_cfg_pkg::module_set_s inv, // Modules present
	input wire logic det_on, // Bus traffic present at det_code
	input wire logic [3:0] det_code, // Rate of the traffic
	input wire logic [63:0] din, // Input channel levels
	output logic [31:0] module_set_pin, // Inventory to block
	output logic auto_rate_found, // Detector result
	output logic [3:0] auto_rate_code, // Detected rate
	output logic [63:0] dig_in_pin // Inputs to block
);
	logic [2:0] seen_q;
	assign module_set_pin = inv;
	assign auto_rate_code = auto_rate_found ? det_code : ~det_code;
	assign auto_rate_found = (seen_q == 3'h5);
	// Detection needs several telegrams, so it reports only after a while
	always_ff @(posedge pclk or negedge presetn)
		if (!presetn)
			seen_q <= 3'h0;
		else if (!det_on)
			seen_q <= 3'h0;
		else if (seen_q != 3'h5)
			seen_q <= seen_q + 3'h1;
	always_ff @(posedge pclk)
		dig_in_pin <= din;
endmodule : io_side_model

/* File: sim/testbench.sv */
// Self-checking bench for the bit-rate and process-data mapping block
`timescale 1ns/1ps
module testbench;
	logic pclk = 0, presetn = 0, psel = 0, penable = 0, pwrite = 0, det_on = 0;
	logic [13:0] paddr = 14'h0000;
	logic [31:0] pwdata = 32'h00000000, prdata, module_set_pin, rd;
	logic pready, pslverr, auto_rate_found, rate_valid, startup_busy, er;
	logic [3:0] auto_rate_code, rate_code, det_code = 4'h4;
	logic [63:0] din = 64'h0123456789ABCDEF, dig_in_pin, dig_out_q;
	pdo_cfg_pkg::module_set_s inv = '0;
	int err_total = 0, checks_done = 0;
	always #50 pclk = ~pclk;
	canopen_baud_and_pdo_mapping u_canopen_baud_and_pdo_mapping (.pclk(pclk), .presetn(presetn), .psel(psel),
		.penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
		.pslverr(pslverr), .module_set_pin(module_set_pin), .auto_rate_found(auto_rate_found),
		.auto_rate_code(auto_rate_code), .dig_in_pin(dig_in_pin), .rate_code(rate_code),
		.rate_valid(rate_valid), .dig_out_q(dig_out_q), .startup_busy(startup_busy));
	io_side_model u_io_side_model (.pclk(pclk), .presetn(presetn), .inv(inv), .det_on(det_on),
		.det_code(det_code), .din(din), .module_set_pin(module_set_pin), .auto_rate_found(auto_rate_found),
		.auto_rate_code(auto_rate_code), .dig_in_pin(dig_in_pin));
	// ----------------------------------------
	// Shared tasks
	// ----------------------------------------
	task automatic give_verdict();
		$display("Comparisons %0d, mismatches %0d", checks_done, err_total);
		if (err_total == 0 && checks_done > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask : give_verdict
	task automatic check32(input string what, input logic [31:0] exp, input logic [31:0] got);
		checks_done++;
		if (got !== exp)
		begin
			err_total++;
			$display("ERROR %s expected %h seen %h", what, exp, got);
		end
	endtask : check32
	// Ready is sampled at the rising edge; the request stands unchanged until then
	task automatic apb(input logic w, input logic [11:0] idx, input logic [31:0] wd);
		int n;
		n = 0;
		@(posedge pclk);
		psel <= 1;
		penable <= 0;
		pwrite <= w;
		paddr <= {idx, 2'b00};
		pwdata <= wd;
		@(posedge pclk);
		penable <= 1;
		do @(posedge pclk); while (pready !== 1'b1 && ++n < 20);
		if (n >= 20)
		begin
			check32("bus timeout", 32'h1, 32'h0);
			give_verdict();
		end
		rd = prdata;
		er = pslverr;
		psel <= 0;
		penable <= 0;
	endtask : apb
	task automatic rd_chk(input string what, input logic [11:0] idx, input logic [31:0] exp);
		apb(0, idx, 32'h00000000);
		check32(what, exp, rd);
	endtask : rd_chk
	task automatic wait_scan();
		int n;
		n = 0;
		// A restart raises busy only a couple of edges after the write lands
		while (startup_busy !== 1'b1 && n < 8)
		begin
			@(posedge pclk);
			n++;
		end
		check32("scan started", 32'h1, {31'h0, startup_busy});
		n = 0;
		do @(posedge pclk); while (startup_busy !== 1'b0 && ++n < 300);
		check32("scan finished", 32'h0, {31'h0, startup_busy});
	endtask : wait_scan
	task automatic restart();
		apb(1, pdo_cfg_pkg::idx_restart, 32'h00000001);
		wait_scan();
	endtask : restart
	// ----------------------------------------
	// Scenarios
	// ----------------------------------------
	task automatic t_auto_rate();
		check32("busy in reset", 32'h1, {31'h0, startup_busy});
		apb(1, pdo_cfg_pkg::idx_fixed_rate, 32'h00000007);
		rd_chk("locked code", pdo_cfg_pkg::idx_fixed_rate, 32'h00000000);
		det_on <= 1;
		wait_scan();
		check32("auto rate", 32'h4, {28'h0, rate_code});
		det_on <= 0;
		apb(1, pdo_cfg_pkg::idx_write_prot, 32'h00000001);
		apb(1, pdo_cfg_pkg::idx_fixed_rate, 32'h00000007);
		restart();
		check32("inactive code", 32'h4, {28'h0, rate_code});
	endtask : t_auto_rate
	task automatic t_fixed_rate();
		apb(1, pdo_cfg_pkg::idx_write_prot, 32'h00000001);
		apb(1, pdo_cfg_pkg::idx_fixed_rate, 32'h00000007);
		apb(1, pdo_cfg_pkg::idx_activation, 32'h00008000);
		apb(1, pdo_cfg_pkg::idx_auto_rate, 32'h00000001);
		rd_chk("code", pdo_cfg_pkg::idx_fixed_rate, 32'h00000007);
		rd_chk("activation", pdo_cfg_pkg::idx_activation, 32'h00008000);
		check32("old rate kept", 32'h4, {28'h0, rate_code});
		restart();
		check32("fixed rate", 32'h7, {28'h0, rate_code});
		check32("rate held", 32'h1, {31'h0, rate_valid});
	endtask : t_fixed_rate
	task automatic t_mapping();
		inv <= '{n_dig_in: 8'h10, n_dig_out: 8'h00, n_ana_in: 4'h2, n_ana_out: 4'h0,
			n_spc_in_bytes: 4'h4, n_spc_out_bytes: 4'h0};
		restart();
		rd_chk("rx1 count", pdo_cfg_pkg::idx_map_count, 32'h00000000);
		rd_chk("tx1 count", 12'h030, 32'h00000002);
		rd_chk("tx1 sub1", 12'h0A0, 32'h60000108);
		rd_chk("tx1 sub2", 12'h0A1, 32'h60000208);
		rd_chk("tx1 past end", 12'h0A2, 32'h00000000);
		rd_chk("rx2 count", 12'h021, 32'h00000000);
		apb(0, 12'h0A8, 32'h00000000);
		check32("tx2 object", {16'h0, pdo_cfg_pkg::obj_ana_in}, {16'h0, rd[31:16]});
		apb(0, 12'h0B0, 32'h00000000);
		check32("tx3 object", {16'h0, pdo_cfg_pkg::obj_spc_in}, {16'h0, rd[31:16]});
	endtask : t_mapping
	task automatic t_dio();
		apb(1, pdo_cfg_pkg::idx_dio_base, 32'hA5C3F00F);
		apb(1, 12'h101, 32'h12345678);
		@(posedge pclk);
		check32("out lo", 32'hA5C3F00F, dig_out_q[31:0]);
		check32("out hi", 32'h12345678, dig_out_q[63:32]);
		rd_chk("in lo", 12'h102, din[31:0]);
		rd_chk("in hi", 12'h103, din[63:32]);
	endtask : t_dio
	task automatic t_ids_modes();
		rd_chk("tx1 id", 12'h050, 32'h0000018B);
		rd_chk("rx1 id", pdo_cfg_pkg::idx_pdo_base, 32'h0000020B);
		rd_chk("rx5 id off", 12'h044, 32'h00008000);
		apb(1, pdo_cfg_pkg::idx_id_ext, 32'h00000001);
		apb(0, 12'h044, 32'h00000000);
		check32("rx5 id on", 32'h0, {31'h0, rd[15]});
		apb(1, 12'h04F, 32'h000003A5);
		rd_chk("rx16 id", 12'h04F, 32'h000003A5);
		rd_chk("mode default", 12'h060, 32'h00000000);
		for (int m = 1; m < 4; m++)
		begin
			apb(1, 12'h060, m);
			rd_chk("mode", 12'h060, (m == 3) ? 32'h2 : m);
		end
		apb(0, 12'h7FF, 32'h00000000);
		check32("unmapped error", 32'h1, {31'h0, er});
	endtask : t_ids_modes
	initial
	begin
		repeat (16) @(posedge pclk);
		presetn <= 1;
		t_auto_rate();
		t_fixed_rate();
		t_mapping();
		t_dio();
		t_ids_modes();
		give_verdict();
	end
endmodule : testbench
